// File: src/cmp_consts.svh
// Operation
// - raw result is low when plus input is below minus input, high when above.
// - enable bit turns the comparator on; clear means off at lowest consumption.
// - result readable as status bit in control and as bit in summary register.
// - pin driven only when routed there, direction is output, and comparator enabled.
// - internal result registered each instruction cycle; pin output passes unlatched when the glitch filter is off.
// - invert bit at 0 passes the result, at 1 inverts it.
// - hysteresis enable bit adds separation voltage; clearing it removes hysteresis.
// - output offered as gate-control source for the gated timer.
// - sync bit latches output on gated timer clock falling edge, after prescaler.
// - gated timer counts on rising clock edge, opposite to the latch edge.
// - separate rise and fall detectors; an enabled edge sets the irq flag.
// - irq reaches the core only with enable, irq enable, group and global enables.
// - only software clears the flag; an edge during the clear keeps it set.
// - toggling invert or enable while off can still raise an edge interrupt.
// - three-bit positive select routes pin, ramp, converter, reference or ground.
// - with enable clear all input selections are disconnected.
// - three-bit negative select routes pin, fixed reference or analog ground.
// - with glitch filter on, a change cannot reverse for a nominal interval.
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_OFF_CTRL_A   32'h0000_0000
`define CMP_OFF_CTRL_B   32'h0000_0004
`define CMP_OFF_SUMMARY  32'h0000_0008
`define CMP_OFF_IRQ      32'h0000_000C

`define CMP_A_EN      7
`define CMP_A_RESULT  6
`define CMP_A_INV     4
`define CMP_A_FILT    3
`define CMP_A_SPEED   2
`define CMP_A_HYS     1
`define CMP_A_SYNC    0
`define CMP_A_WMASK   8'h9F
`define CMP_A_RESET   8'h04

`define CMP_B_RISE    7
`define CMP_B_FALL    6
`define CMP_B_POS_HI  5
`define CMP_B_POS_LO  3
`define CMP_B_NEG_HI  2
`define CMP_B_NEG_LO  0
`define CMP_B_RESET   8'h00

`define CMP_Q_FLAG    0
`define CMP_Q_IE      1
`define CMP_Q_GRP     2
`define CMP_Q_GLB     3
`define CMP_Q_WMASK   4'hE
`define CMP_Q_RESET   4'h0

`define CMP_RESP_OKAY   2'h0
`define CMP_RESP_SLVERR 2'h2

`define CMP_FILT_NS   20
`define CMP_CLK_MHZ   40
`define CMP_FILT_RAW  ((`CMP_FILT_NS * `CMP_CLK_MHZ) / 1000)
`define CMP_FILT_CYC  ((`CMP_FILT_RAW < 1) ? 1 : `CMP_FILT_RAW)

`endif

// File: src/cmp_pkg.sv
package cmp_pkg;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic       enable;
    logic       high_speed;
    logic       hysteresis_enable;
    logic       inputs_connected;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } analog_ctrl_t;

endpackage : cmp_pkg

// File: src/comparator_output_logic.sv
`timescale 1ns/1ps
`include "cmp_consts.svh"

module comparator_output_logic (
  // clock, reset, freeze
  input  wire  logic              i_clk_sys,
  input  wire  logic              i_rst,
  input  wire  logic              i_ce,
  // register bus
  input  wire  cmp_pkg::axi_req_t i_axi,
  output       cmp_pkg::axi_rsp_t o_axi,
  // analog front end
  input  wire  logic              i_raw_result,
  output       cmp_pkg::analog_ctrl_t o_analog,
  // output pin
  input  wire  logic              i_pin_route,
  input  wire  logic              i_pin_dir,
  output logic                    o_pin_out,
  output logic                    o_pin_oe,
  // gated timer
  input  wire  logic              i_tmr_clk,
  output logic                    o_gate_src,
  output logic                    o_tmr_count_edge,
  // result and interrupt
  output logic                    o_result,
  output logic                    o_cmp_irq
);
  import cmp_pkg::*;

  // register state
  logic [7:0]  cmp_control_a;
  logic [7:0]  cmp_control_b;
  logic [3:0]  irq_ctrl;
  logic [7:0]  next_cmp_control_a;
  logic [7:0]  next_cmp_control_b;
  logic [3:0]  next_irq_ctrl;

  // bus state
  logic        aw_hold;
  logic [31:0] aw_addr;
  logic        w_hold;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_aw_hold;
  logic [31:0] next_aw_addr;
  logic        next_w_hold;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // datapath state
  logic        filt_out;
  logic [3:0]  filt_hold;
  logic        result;
  logic        result_prev;
  logic        tmr_prev;
  logic        sync_latch;
  logic        next_filt_out;
  logic [3:0]  next_filt_hold;
  logic        next_sync_latch;

  // combinational helpers
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        flag_clear;
  logic        polar;
  logic        ext_out;
  logic        rise_seen;
  logic        fall_seen;
  logic        tmr_fall;
  logic        en;

  assign en = cmp_control_a[`CMP_A_EN];

  // register bus
  assign o_axi.awready = !aw_hold && !bvalid;
  assign o_axi.wready  = !w_hold && !bvalid;
  assign o_axi.arready = !rvalid;
  assign o_axi.bvalid  = bvalid;
  assign o_axi.bresp   = bresp;
  assign o_axi.rvalid  = rvalid;
  assign o_axi.rdata   = rdata;
  assign o_axi.rresp   = rresp;

  assign aw_take  = i_axi.awvalid && o_axi.awready;
  assign w_take   = i_axi.wvalid && o_axi.wready;
  assign wr_addr  = aw_hold ? aw_addr : i_axi.awaddr;
  assign wr_data  = w_hold ? w_data : i_axi.wdata;
  assign wr_strb  = w_hold ? w_strb : i_axi.wstrb;
  // address and data may arrive in either order; the write lands once both are in
  assign do_write = (aw_hold || aw_take) && (w_hold || w_take) && !bvalid;
  assign flag_clear = do_write && wr_strb[0] && wr_data[`CMP_Q_FLAG]
                      && ({wr_addr[31:2], 2'b00} == `CMP_OFF_IRQ);

  always_comb begin
    next_aw_hold       = aw_hold;
    next_aw_addr       = aw_addr;
    next_w_hold        = w_hold;
    next_w_data        = w_data;
    next_w_strb        = w_strb;
    next_bvalid        = bvalid;
    next_bresp         = bresp;
    next_rvalid        = rvalid;
    next_rdata         = rdata;
    next_rresp         = rresp;
    next_cmp_control_a = cmp_control_a;
    next_cmp_control_b = cmp_control_b;
    next_irq_ctrl      = irq_ctrl;
    if (aw_take) begin
      next_aw_hold = 1'b1;
      next_aw_addr = i_axi.awaddr;
    end
    if (w_take) begin
      next_w_hold = 1'b1;
      next_w_data = i_axi.wdata;
      next_w_strb = i_axi.wstrb;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `CMP_RESP_OKAY;
      case ({wr_addr[31:2], 2'b00})
        `CMP_OFF_CTRL_A: begin
          if (wr_strb[0]) begin
            next_cmp_control_a = wr_data[7:0] & `CMP_A_WMASK;
          end
        end
        `CMP_OFF_CTRL_B: begin
          if (wr_strb[0]) begin
            next_cmp_control_b = wr_data[7:0];
          end
        end
        `CMP_OFF_IRQ: begin
          if (wr_strb[0]) begin
            next_irq_ctrl = (irq_ctrl & ~`CMP_Q_WMASK)
                            | (wr_data[3:0] & `CMP_Q_WMASK);
          end
        end
        `CMP_OFF_SUMMARY: begin
          next_bresp = `CMP_RESP_OKAY;
        end
        default: begin
          next_bresp = `CMP_RESP_SLVERR;
        end
      endcase
    end
    // flag: only software clears it, and a fresh edge outranks the clear
    next_irq_ctrl[`CMP_Q_FLAG] = (irq_ctrl[`CMP_Q_FLAG] && !flag_clear)
                                 || rise_seen || fall_seen;
    if (bvalid && i_axi.bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && i_axi.rready) begin
      next_rvalid = 1'b0;
    end
    if (i_axi.arvalid && o_axi.arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `CMP_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case ({i_axi.araddr[31:2], 2'b00})
        `CMP_OFF_CTRL_A: begin
          next_rdata[7:0] = cmp_control_a;
          next_rdata[`CMP_A_RESULT] = result;
        end
        `CMP_OFF_CTRL_B: begin
          next_rdata[7:0] = cmp_control_b;
        end
        `CMP_OFF_SUMMARY: begin
          next_rdata[0] = result;
        end
        `CMP_OFF_IRQ: begin
          next_rdata[3:0] = irq_ctrl;
        end
        default: begin
          next_rresp = `CMP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_hold       <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_hold        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      bvalid        <= 1'b0;
      bresp         <= `CMP_RESP_OKAY;
      rvalid        <= 1'b0;
      rdata         <= 32'h0000_0000;
      rresp         <= `CMP_RESP_OKAY;
      cmp_control_a <= `CMP_A_RESET;
      cmp_control_b <= `CMP_B_RESET;
      irq_ctrl      <= `CMP_Q_RESET;
    end else if (i_ce) begin
      aw_hold       <= next_aw_hold;
      aw_addr       <= next_aw_addr;
      w_hold        <= next_w_hold;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      bvalid        <= next_bvalid;
      bresp         <= next_bresp;
      rvalid        <= next_rvalid;
      rdata         <= next_rdata;
      rresp         <= next_rresp;
      cmp_control_a <= next_cmp_control_a;
      cmp_control_b <= next_cmp_control_b;
      irq_ctrl      <= next_irq_ctrl;
    end
  end

  // analog controls
  // a disabled comparator parks its muxes so no source is loaded
  always_comb begin
    o_analog.enable                = en;
    o_analog.high_speed            = cmp_control_a[`CMP_A_SPEED];
    o_analog.hysteresis_enable     = en && cmp_control_a[`CMP_A_HYS];
    o_analog.inputs_connected      = en;
    o_analog.positive_input_select = 3'h0;
    o_analog.negative_input_select = 3'h0;
    if (en) begin
      o_analog.positive_input_select =
        cmp_control_b[`CMP_B_POS_HI:`CMP_B_POS_LO];
      o_analog.negative_input_select =
        cmp_control_b[`CMP_B_NEG_HI:`CMP_B_NEG_LO];
    end
  end

  // output path
  // off forces the raw level low, so invert and enable toggles still make edges
  assign polar = (en && i_raw_result) ^ cmp_control_a[`CMP_A_INV];

  // one registered cycle already outlasts the nominal blocking time at this clock,
  // so the hold count only comes into play if the clock is raised
  always_comb begin
    next_filt_out  = polar;
    next_filt_hold = 4'h0;
    if (filt_hold != 4'h0) begin
      next_filt_out  = filt_out;
      next_filt_hold = filt_hold - 4'h1;
    end else if (polar != filt_out) begin
      next_filt_hold = 4'(`CMP_FILT_CYC - 1);
    end
  end

  // pin path stays combinational when unfiltered, at the cost of possible glitches
  assign ext_out   = cmp_control_a[`CMP_A_FILT] ? filt_out : polar;
  assign tmr_fall  = tmr_prev && !i_tmr_clk;
  assign rise_seen = result && !result_prev
                     && cmp_control_b[`CMP_B_RISE];
  assign fall_seen = !result && result_prev
                     && cmp_control_b[`CMP_B_FALL];

  always_comb begin
    next_sync_latch = sync_latch;
    if (tmr_fall) begin
      next_sync_latch = ext_out;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      filt_out    <= 1'b0;
      filt_hold   <= 4'h0;
      result      <= 1'b0;
      result_prev <= 1'b0;
      tmr_prev    <= 1'b0;
      sync_latch  <= 1'b0;
    end else if (i_ce) begin
      filt_out    <= next_filt_out;
      filt_hold   <= next_filt_hold;
      result      <= ext_out;
      result_prev <= result;
      tmr_prev    <= i_tmr_clk;
      sync_latch  <= next_sync_latch;
    end
  end

  assign o_result         = result;
  assign o_pin_out        = ext_out;
  assign o_pin_oe         = i_pin_route && !i_pin_dir && en;
  assign o_gate_src       = cmp_control_a[`CMP_A_SYNC] ? sync_latch : result;
  assign o_tmr_count_edge = !tmr_prev && i_tmr_clk;
  assign o_cmp_irq        = irq_ctrl[`CMP_Q_FLAG] && en && irq_ctrl[`CMP_Q_IE]
                            && irq_ctrl[`CMP_Q_GRP] && irq_ctrl[`CMP_Q_GLB];

endmodule : comparator_output_logic

// File: test/cmp_properties.sv
`timescale 1ns/1ps
module cmp_checker (
  // watched design ports
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst,
  input wire logic                  i_ce,
  input wire cmp_pkg::axi_req_t     i_axi,
  input wire cmp_pkg::axi_rsp_t     o_axi,
  input wire cmp_pkg::analog_ctrl_t o_analog,
  input wire logic                  i_pin_route,
  input wire logic                  i_pin_dir,
  input wire logic                  i_tmr_clk,
  input wire logic                  o_pin_out,
  input wire logic                  o_pin_oe,
  input wire logic                  o_tmr_count_edge,
  input wire logic                  o_result,
  input wire logic                  o_cmp_irq
);
  import cmp_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  pin_enable_a: assert property (
    o_pin_oe == (i_pin_route & !i_pin_dir & o_analog.enable)) else $error("pin enable");
  inputs_off_a: assert property (
    !o_analog.enable |-> !o_analog.inputs_connected && o_analog.positive_input_select == 3'h0
      && o_analog.negative_input_select == 3'h0) else $error("inputs connected");
  hys_gate_a: assert property (
    o_analog.hysteresis_enable |-> o_analog.enable) else $error("hysteresis while off");
  result_reg_a: assert property (
    $past(i_ce) && !$past(i_rst) |-> o_result == $past(o_pin_out)) else $error("result reg");
  count_edge_a: assert property (
    $past(i_ce) && !$past(i_rst) |-> o_tmr_count_edge == (i_tmr_clk && !$past(i_tmr_clk)))
    else $error("count edge");
  irq_gate_a: assert property (
    o_cmp_irq |-> o_analog.enable) else $error("irq while off");
  irq_clear_a: assert property (
    $fell(o_cmp_irq) && !$past(i_rst) |-> $past(i_axi.awvalid && o_axi.awready
      || i_axi.wvalid && o_axi.wready)) else $error("irq fell without write");
  read_hold_a: assert property (
    o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read data dropped");
endmodule : cmp_checker

// File: test/cmp_far_side.sv
`timescale 1ns/1ps
module cmp_far_side (
  // controls
  input  wire logic   i_clk_sys,
  input  wire logic   i_level,
  input  wire logic   i_tmr_run,
  // from the comparator
  input  wire logic   i_gate_src,
  input  wire logic   i_count_edge,
  // towards the comparator, plus the timer count back to the bench
  output logic        o_raw_result,
  output logic        o_tmr_clk = 1'b0,
  output logic [15:0] o_count = 16'h0000
);
  logic [1:0] div = 2'h0;
  // ideal analog stage, high when the plus input is above the minus input
  assign o_raw_result = i_level;
  always @(posedge i_clk_sys) begin
    div <= i_tmr_run ? div + 2'h1 : 2'h0;
    // timer clock stands low while the timer is unused
    if (!i_tmr_run)
      o_tmr_clk <= 1'b0;
    else if (div == 2'h3)
      o_tmr_clk <= !o_tmr_clk;
    // counts on the rising point, away from the latching edge
    if (i_count_edge && i_gate_src)
      o_count <= o_count + 16'h0001;
  end
endmodule : cmp_far_side

// File: test/tb_comparator_output_logic.sv
`timescale 1ns/1ps
`include "cmp_consts.svh"
module tb_comparator_output_logic;
  import cmp_pkg::*;
  logic         clk, rst, ce, lvl, trun, route, dir, raw, tclk;
  logic         pout, poe, gate, cedge, res, irq;
  axi_req_t     req;
  axi_rsp_t     rsp;
  analog_ctrl_t ana;
  logic [15:0]  tcnt;
  logic [31:0]  d;
  logic [1:0]   r;
  int           mismatches, n_checks;

  comparator_output_logic dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_axi(req),
    .o_axi(rsp), .i_raw_result(raw), .o_analog(ana), .i_pin_route(route), .i_pin_dir(dir),
    .o_pin_out(pout), .o_pin_oe(poe), .i_tmr_clk(tclk), .o_gate_src(gate),
    .o_tmr_count_edge(cedge), .o_result(res), .o_cmp_irq(irq));
  cmp_far_side far (.i_clk_sys(clk), .i_level(lvl), .i_tmr_run(trun), .i_gate_src(gate),
    .i_count_edge(cedge), .o_raw_result(raw), .o_tmr_clk(tclk), .o_count(tcnt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t ns: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  task automatic set_lvl(input logic v);
    @(posedge clk);
    lvl <= v;
  endtask : set_lvl

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic aw, w, ta, tw;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= {24'h00_0000, v};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // each channel drops only once its own ready was seen; readies are looked at
    // mid-cycle, since they move on the very edge that takes the channel
    while (aw || w) begin
      @(negedge clk);
      ta = rsp.awready;
      tw = rsp.wready;
      @(posedge clk);
      if (ta) aw = 1'b0;
      if (tw) w = 1'b0;
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    do @(negedge clk); while (!rsp.bvalid);
    r = rsp.bresp;
    @(posedge clk);
    req.bready <= 1'b0;
  endtask : wr

  task automatic rc(input logic [31:0] a, input logic [7:0] m, e);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(negedge clk); while (!rsp.arready);
    @(posedge clk);
    req.arvalid <= 1'b0;
    do @(negedge clk); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge clk);
    req.rready <= 1'b0;
    chk(d & {24'hFF_FFFF, m}, {24'h00_0000, e});
  endtask : rc

  task automatic lv(input logic v, e);
    set_lvl(v);
    cyc(3);
    chk(irq, e);
  endtask : lv

  task automatic t_polarity();
    for (int i = 0; i < 8; i++) begin
      logic e;
      e = (i[2] & i[0]) ^ i[1];
      wr(`CMP_OFF_CTRL_A, {i[2], 2'h0, i[1], 4'h4});
      set_lvl(i[0]);
      dir <= i[0];
      cyc(2);
      chk(pout, e);
      chk(res, e);
      chk(poe, i[2] & !i[0]);
      rc(`CMP_OFF_CTRL_A, 8'h40, {1'b0, e, 6'h00});
      rc(`CMP_OFF_SUMMARY, 8'h01, {7'h00, e});
    end
  endtask : t_polarity

  task automatic t_irq();
    logic [7:0] m [3] = '{8'h0C, 8'h0A, 8'h06};
    wr(`CMP_OFF_CTRL_A, 8'h84);
    wr(`CMP_OFF_CTRL_B, 8'h80);
    lv(1'b0, 1'b0);
    wr(`CMP_OFF_IRQ, 8'h0F);
    lv(1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(`CMP_OFF_IRQ, m[i]);
      chk(irq, 1'b0);
    end
    wr(`CMP_OFF_IRQ, 8'h0E);
    chk(irq, 1'b1);
    wr(`CMP_OFF_IRQ, 8'h0F);
    chk(irq, 1'b0);
    lv(1'b0, 1'b0);
    wr(`CMP_OFF_CTRL_B, 8'h40);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b1);
    // the clear lands on the very edge that records a new rise
    wr(`CMP_OFF_CTRL_B, 8'hC0);
    set_lvl(1'b1);
    wr(`CMP_OFF_IRQ, 8'h0F);
    rc(`CMP_OFF_IRQ, 8'h01, 8'h01);
    set_lvl(1'b0);
    cyc(3);
    wr(`CMP_OFF_IRQ, 8'h0F);
    wr(`CMP_OFF_CTRL_B, 8'hC0);
    wr(`CMP_OFF_CTRL_A, 8'h04);
    // switched off, only the invert bit makes this edge
    wr(`CMP_OFF_CTRL_A, 8'h14);
    rc(`CMP_OFF_IRQ, 8'h01, 8'h01);
    chk(irq, 1'b0);
    wr(`CMP_OFF_IRQ, 8'h0F);
    rc(`CMP_OFF_IRQ, 8'h01, 8'h00);
  endtask : t_irq

  task automatic t_inputs();
    wr(`CMP_OFF_CTRL_A, 8'h86);
    for (int i = 0; i < 5; i++) begin
      wr(`CMP_OFF_CTRL_B, {2'h0, i[2:0], 3'(i % 3)});
      chk(ana, {4'hF, i[2:0], 3'(i % 3)});
    end
    wr(`CMP_OFF_CTRL_A, 8'h04);
    chk(ana, 10'h100);
  endtask : t_inputs

  task automatic t_sync();
    logic [15:0] n;
    wr(`CMP_OFF_CTRL_A, 8'h81);
    @(posedge clk);
    trun <= 1'b1;
    @(posedge tclk);
    set_lvl(1'b1);
    cyc(1);
    chk(gate, 1'b0);
    @(negedge tclk);
    cyc(2);
    chk(gate, 1'b1);
    n = tcnt;
    @(posedge tclk);
    cyc(1);
    chk(tcnt, n + 16'h0001);
    wr(`CMP_OFF_CTRL_A, 8'h80);
    set_lvl(1'b0);
    cyc(2);
    chk(gate, 1'b0);
    @(posedge clk);
    trun <= 1'b0;
    ce <= 1'b0;
    lvl <= 1'b1;
    cyc(3);
    chk(res, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    cyc(2);
    chk(res, 1'b1);
  endtask : t_sync

  task automatic t_filter();
    logic [3:0] seen;
    seen = 4'h0;
    wr(`CMP_OFF_CTRL_A, 8'h8C);
    set_lvl(1'b0);
    cyc(3);
    set_lvl(1'b1);
    set_lvl(1'b0);
    // a one-cycle pulse comes out one cycle late and stands a whole cycle
    repeat (4) begin
      @(negedge clk);
      seen = {seen[2:0], pout};
    end
    chk(seen, 4'h8);
  endtask : t_filter

  task automatic t_bus();
    rc(32'h0000_0010, 8'hFF, 8'h00);
    chk(r, `CMP_RESP_SLVERR);
    wr(32'h0000_0010, 8'hFF);
    chk(r, `CMP_RESP_SLVERR);
    wr(`CMP_OFF_SUMMARY, 8'hFF);
    chk(r, `CMP_RESP_OKAY);
  endtask : t_bus

  initial begin
    #400_000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    {rst, ce, route} = 3'h7;
    {lvl, trun, dir} = 3'h0;
    req = '0;
    req.wstrb = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc(`CMP_OFF_CTRL_A, 8'hFF, 8'h04);
    rc(`CMP_OFF_CTRL_B, 8'hFF, 8'h00);
    chk(ana, 10'h100);
    t_polarity();
    t_irq();
    t_inputs();
    t_sync();
    t_filter();
    t_bus();
    report_and_stop();
  end
endmodule : tb_comparator_output_logic

bind comparator_output_logic cmp_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_ce(i_ce), .i_axi(i_axi), .o_axi(o_axi), .o_analog(o_analog), .i_pin_route(i_pin_route),
  .i_pin_dir(i_pin_dir), .i_tmr_clk(i_tmr_clk), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_tmr_count_edge(o_tmr_count_edge), .o_result(o_result), .o_cmp_irq(o_cmp_irq));
